// *** mxf_top.sv ***
// Purpose: Registered model of a family of data selectors.
// Assumes: Inputs synchronous to REF_CLK_I; reset synchronous, active high.
// Notes: Every output is a flip-flop, so results appear one clock after inputs.
`timescale 1ns/10ps
`default_nettype none
module mxf_top #(
  parameter int WOR_UNITS = 2
) (
  // Clock and reset.
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  // Quad two-way selector.
  input wire mxf_pkg::mxf_quad_s QUAD_I,
  output logic [3:0] QUAD_Z_O,
  // Dual four-way selectors.
  input wire mxf_pkg::mxf_dual_s DUAL_I,
  output logic [1:0] DUAL_Z_O,
  output logic [1:0] DUAL_ZN_O,
  output logic [1:0] DUALEN_Z_O,
  // Eight-way selector.
  input wire logic [7:0] OCT_DATA_I,
  input wire logic [2:0] OCT_SEL_I,
  input wire logic OCT_ENABLE_N_I,
  output logic OCT_Z_O,
  output logic OCT_ZN_O,
  // Wire-OR array of eight-way units.
  input wire logic [WOR_UNITS*8-1:0] WOR_DATA_I,
  input wire logic [2:0] WOR_SEL_I,
  input wire logic [WOR_UNITS-1:0] WOR_ENABLE_N_I,
  output logic WOR_Z_O,
  output logic WOR_ZN_O
);
  // Refuse an array with no units, which would leave the wired node undriven.
  if (WOR_UNITS < 1) begin : g_units_check
    $error("WOR_UNITS must be at least one");
  end

  logic [1:0] dsel;
  logic [1:0] dual_pick;
  logic [WOR_UNITS-1:0] wor_true;
  logic wor_node;

  // Shared select code with bit zero as least significant.
  assign dsel = {DUAL_I.select_bit1, DUAL_I.select_bit0};
  assign dual_pick = {DUAL_I.data[4 + dsel], DUAL_I.data[dsel]};

  // Each wire-OR unit's true term; complements tie low-wins, i.e. node is NOR of trues.
  always_comb begin
    for (int u = 0; u < WOR_UNITS; u++) begin
      wor_true[u] = ~WOR_ENABLE_N_I[u] & WOR_DATA_I[u*8 + int'(WOR_SEL_I)];
    end
  end
  assign wor_node = ~(|wor_true);

  // Quad selector output register.
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      QUAD_Z_O <= mxf_pkg::QUAD_RESET;
    end else if (QUAD_I.enable_n) begin
      QUAD_Z_O <= 4'h0;
    end else begin
      QUAD_Z_O <= QUAD_I.select_bit0 ? QUAD_I.source1_lane : QUAD_I.source0_lane;
    end
  end

  // Dual selector with true and complement outputs.
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      DUAL_Z_O <= mxf_pkg::DUAL_Z_RESET;
      DUAL_ZN_O <= mxf_pkg::DUAL_ZN_RESET;
    end else begin
      DUAL_Z_O <= dual_pick;
      DUAL_ZN_O <= ~dual_pick;
    end
  end

  // Dual selector with an independent enable per section.
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      DUALEN_Z_O <= mxf_pkg::DUALEN_RESET;
    end else begin
      DUALEN_Z_O[0] <= ~DUAL_I.enable_a_n & dual_pick[0];
      DUALEN_Z_O[1] <= ~DUAL_I.enable_b_n & dual_pick[1];
    end
  end

  // Eight-way selector.
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I || OCT_ENABLE_N_I) begin
      OCT_Z_O <= mxf_pkg::OCT_TRUE_IDLE;
      OCT_ZN_O <= mxf_pkg::OCT_COMP_IDLE;
    end else begin
      OCT_Z_O <= OCT_DATA_I[OCT_SEL_I];
      OCT_ZN_O <= ~OCT_DATA_I[OCT_SEL_I];
    end
  end

  // Wire-OR node and its inverse.
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      WOR_ZN_O <= mxf_pkg::WOR_ZN_RESET;
      WOR_Z_O <= mxf_pkg::WOR_Z_RESET;
    end else begin
      WOR_ZN_O <= wor_node;
      WOR_Z_O <= ~wor_node;
    end
  end

  // Quad outputs follow the chosen source one clock later.
  quad_route_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    1'b1 |=> QUAD_Z_O == ($past(QUAD_I.enable_n) ? 4'h0 :
      ($past(QUAD_I.select_bit0) ? $past(QUAD_I.source1_lane) : $past(QUAD_I.source0_lane))))
    else $error("quad selector output wrong");
  quad_disable_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    QUAD_I.enable_n |=> QUAD_Z_O == 4'h0)
    else $error("quad outputs not low while disabled");
  quad_select_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    !QUAD_I.enable_n && !QUAD_I.select_bit0 |=> QUAD_Z_O == $past(QUAD_I.source0_lane))
    else $error("select low did not pass source zero");
  dual_pair_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    1'b1 |=> DUAL_ZN_O == ~DUAL_Z_O && DUAL_Z_O[1] == $past(DUAL_I.data[4 + dsel]))
    else $error("dual selector outputs wrong");
  dual_enable_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    !DUAL_I.enable_a_n |=> DUALEN_Z_O[0] == DUAL_Z_O[0])
    else $error("enabled section does not follow select");
  dual_off_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    DUAL_I.enable_b_n |=> DUALEN_Z_O[1] == 1'b0)
    else $error("disabled section not low");
  oct_route_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    !OCT_ENABLE_N_I |=> OCT_Z_O == $past(OCT_DATA_I[OCT_SEL_I]) && OCT_ZN_O == !OCT_Z_O)
    else $error("eight-way selector output wrong");
  oct_idle_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    OCT_ENABLE_N_I |=> !OCT_Z_O && OCT_ZN_O)
    else $error("eight-way selector not idle while disabled");
  wor_invert_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    (&WOR_ENABLE_N_I) |=> WOR_ZN_O && !WOR_Z_O)
    else $error("wire-OR node not high with all units off");

  // Further quad checks: the second source, the lane choice and the forced low level.
  quad_select_high_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    !QUAD_I.enable_n && QUAD_I.select_bit0
    |=> QUAD_Z_O == $past(QUAD_I.source1_lane))
    else $error("select high did not pass source one");
  quad_lane_pick_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    !QUAD_I.enable_n
    |=> QUAD_Z_O == $past(QUAD_I.source0_lane) || QUAD_Z_O == $past(QUAD_I.source1_lane))
    else $error("quad outputs match neither source");
  quad_unselect_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    !QUAD_I.enable_n && !QUAD_I.select_bit0 && QUAD_I.source0_lane != QUAD_I.source1_lane
    |=> QUAD_Z_O != $past(QUAD_I.source1_lane))
    else $error("select low passed source one");
  quad_off_sel_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    QUAD_I.enable_n && QUAD_I.select_bit0
    |=> QUAD_Z_O == 4'h0)
    else $error("quad outputs not low while disabled with select high");

  // Fixed select codes pin down the bit order of the shared code.
  dual_code0_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    !DUAL_I.select_bit1 && !DUAL_I.select_bit0
    |=> DUAL_Z_O[0] == $past(DUAL_I.data[0]))
    else $error("code zero did not pick input zero");
  dual_code1_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    !DUAL_I.select_bit1 && DUAL_I.select_bit0
    |=> DUAL_Z_O[0] == $past(DUAL_I.data[1]))
    else $error("code one did not pick input one");
  dual_code2_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    DUAL_I.select_bit1 && !DUAL_I.select_bit0
    |=> DUAL_Z_O[1] == $past(DUAL_I.data[6]))
    else $error("code two did not pick input two of section b");
  dual_code3_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    DUAL_I.select_bit1 && DUAL_I.select_bit0
    |=> DUAL_Z_O[1] == $past(DUAL_I.data[7]))
    else $error("code three did not pick input three of section b");

  // Each enabled section acts on its own enable only.
  dual_b_enable_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    !DUAL_I.enable_b_n
    |=> DUALEN_Z_O[1] == DUAL_Z_O[1])
    else $error("enabled section b does not follow select");
  dual_a_off_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    DUAL_I.enable_a_n
    |=> DUALEN_Z_O[0] == 1'b0)
    else $error("disabled section a not low");
  dual_split_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    DUAL_I.enable_a_n && !DUAL_I.enable_b_n
    |=> DUALEN_Z_O[0] == 1'b0 && DUALEN_Z_O[1] == DUAL_Z_O[1])
    else $error("section enables are not independent");

  // Fixed codes on the eight-way selector, and its complement pairing.
  oct_code0_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    !OCT_ENABLE_N_I && OCT_SEL_I == 3'h0
    |=> OCT_Z_O == $past(OCT_DATA_I[0]))
    else $error("eight-way code zero wrong");
  oct_code2_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    !OCT_ENABLE_N_I && OCT_SEL_I == 3'h2
    |=> OCT_Z_O == $past(OCT_DATA_I[2]))
    else $error("eight-way code two wrong");
  oct_code5_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    !OCT_ENABLE_N_I && OCT_SEL_I == 3'h5
    |=> OCT_Z_O == $past(OCT_DATA_I[5]))
    else $error("eight-way code five wrong");
  oct_code7_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    !OCT_ENABLE_N_I && OCT_SEL_I == 3'h7
    |=> OCT_Z_O == $past(OCT_DATA_I[7]))
    else $error("eight-way code seven wrong");
  oct_pair_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    1'b1
    |=> OCT_ZN_O == !OCT_Z_O)
    else $error("eight-way outputs not complementary");

  // A high from any enabled unit pulls the wired node low.
  wor_unit0_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    !WOR_ENABLE_N_I[0] && WOR_DATA_I[WOR_SEL_I]
    |=> !WOR_ZN_O && WOR_Z_O)
    else $error("first wire-OR unit did not pull the node low");
  wor_unit_last_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    !WOR_ENABLE_N_I[WOR_UNITS-1] && WOR_DATA_I[(WOR_UNITS-1)*8 + int'(WOR_SEL_I)]
    |=> !WOR_ZN_O && WOR_Z_O)
    else $error("last wire-OR unit did not pull the node low");
  wor_pair_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    1'b1
    |=> WOR_Z_O == !WOR_ZN_O)
    else $error("wire-OR true output is not the inverse of the node");
endmodule : mxf_top
`default_nettype wire

// *** mxf_pkg.sv ***
// Purpose: Shared constants and carrier types for the selector family.
// Assumes: All selector inputs are synchronous to REF_CLK_I (25 MHz).
// Notes: Outputs of the top module are registered, one clock behind inputs.
// Notes on behaviour
// - Quad selector: one shared select picks a source for each of four lanes.
// - Quad selector: shared active-low enable; when inactive all outputs are low.
// - Quad selector: select low passes source zero, select high source one.
// - Dual four-way selector: shared 2-bit code picks input; true and complement outputs.
// - Dual selector with enables: shared select, independent enable per section.
// - Eight-way selector enabled low: true output is chosen input, complement its inverse.
// - Eight-way selector disabled: true output low, complement output high.
// - Wire-OR variant: complements combine on a node; true output is its inverse.
package mxf_pkg;
  localparam int QUAD_LANES = 4;
  localparam int DUAL_SEL_W = 2;
  localparam int OCT_SEL_W = 3;
  localparam logic [3:0] QUAD_RESET = 4'h0;
  localparam logic OCT_TRUE_IDLE = 1'h0;
  localparam logic OCT_COMP_IDLE = 1'h1;
  localparam logic [1:0] DUAL_Z_RESET = 2'h0;
  localparam logic [1:0] DUAL_ZN_RESET = 2'h3;
  localparam logic [1:0] DUALEN_RESET = 2'h0;
  localparam logic WOR_Z_RESET = 1'h0;
  localparam logic WOR_ZN_RESET = 1'h1;

  // Quad two-way selector inputs.
  typedef struct packed {
    logic [3:0] source0_lane;
    logic [3:0] source1_lane;
    logic select_bit0;
    logic enable_n;
  } mxf_quad_s;

  // Dual four-way selector inputs; section a in [3:0], section b in [7:4].
  typedef struct packed {
    logic [7:0] data;
    logic select_bit1;
    logic select_bit0;
    logic enable_a_n;
    logic enable_b_n;
  } mxf_dual_s;
endpackage : mxf_pkg

// *** mxf_src.sv ***
// Purpose: Upstream logic driving every selector input.
// Assumes: One input set is taken per rising edge.
// Notes: Inputs move one nanosecond after the edge.
`timescale 1ns/10ps
`default_nettype none
module mxf_src (
  // Clock, input set and selector inputs.
  input wire logic clk_i,
  input wire logic [54:0] stim_i,
  output var mxf_pkg::mxf_quad_s quad_o,
  output var mxf_pkg::mxf_dual_s dual_o,
  output logic [11:0] oct_o,
  output logic [20:0] wor_o
);
  // Inputs start low and then follow the set just after each edge.
  initial {quad_o, dual_o, oct_o, wor_o} = '0;
  always @(posedge clk_i) begin
    #1 {quad_o, dual_o, oct_o, wor_o} = stim_i;
  end
endmodule : mxf_src
`default_nettype wire

// *** test_multiplexer_family.sv ***
// Purpose: Self-checking bench for the selector family.
// Assumes: Outputs follow inputs by one clock.
// Notes: Each task sets inputs, waits, then compares.
`timescale 1ns/10ps
`default_nettype none
module test_multiplexer_family;
  logic clk = 0;
  logic rst = 1;
  int n_errors = 0;
  int check_count = 0;
  int cyc = 0;
  mxf_pkg::mxf_quad_s q, qi;
  mxf_pkg::mxf_dual_s d, di;
  logic [11:0] o, oi;
  logic [20:0] w, wi;
  logic [3:0] qz;
  logic [1:0] dz, dzn, dez;
  logic oz, ozn, wz, wzn;
  // The clock, and a watchdog that cuts a hang short.
  always #20 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 500) begin
      n_errors++;
      close_out();
    end
  end
  mxf_src u_mxf_src (.clk_i(clk), .stim_i({q, d, o, w}), .quad_o(qi), .dual_o(di),
    .oct_o(oi), .wor_o(wi));
  mxf_top u_mxf_top (.REF_CLK_I(clk), .RST_I(rst), .QUAD_I(qi), .QUAD_Z_O(qz), .DUAL_I(di),
    .DUAL_Z_O(dz), .DUAL_ZN_O(dzn), .DUALEN_Z_O(dez), .OCT_DATA_I(oi[11:4]),
    .OCT_SEL_I(oi[3:1]), .OCT_ENABLE_N_I(oi[0]), .OCT_Z_O(oz), .OCT_ZN_O(ozn),
    .WOR_DATA_I(wi[20:5]), .WOR_SEL_I(wi[4:2]), .WOR_ENABLE_N_I(wi[1:0]), .WOR_Z_O(wz),
    .WOR_ZN_O(wzn));
  // Compare, count and report.
  task chk(input logic [5:0] got, input logic [5:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  // Let the set be applied and registered.
  task step;
    repeat (2) @(posedge clk);
    #2;
  endtask : step
  task t_quad;
    for (int j = 0; j < 4; j++) begin
      q = {4'h9, 4'h6, j[1:0]};
      step();
      chk(6'(qz), 6'(j[0] ? 4'h0 : j[1] ? 4'h6 : 4'h9));
    end
  endtask : t_quad
  task t_dual;
    for (int j = 0; j < 4; j++) begin
      d = {j[1] ? 4'h1 << j : ~(4'h1 << j), 4'h1 << j, j[1:0], j[0], ~j[0]};
      step();
      chk({dez, dzn, dz}, {j[1] & j[0], ~j[0], ~j[1], 1'b0, j[1], 1'b1});
    end
  endtask : t_dual
  task t_oct;
    for (int j = 0; j < 24; j++) begin
      o = {j[3] ? ~(8'h01 << j[2:0]) : 8'h01 << j[2:0], j[2:0], j[4]};
      step();
      chk(6'({oz, ozn}), j[4] ? 6'h1 : 6'({~j[3], j[3]}));
    end
  endtask : t_oct
  task t_wor;
    for (int j = 0; j < 8; j++) begin
      w = {j[2] ? 8'h00 : 8'h01 << j[2:0], j[2] ? 8'h01 << j[2:0] : 8'h00, j[2:0], j[1:0]};
      step();
      chk(6'({wz, wzn}), j[2] ? 6'({~j[0], j[0]}) : 6'({~j[1], j[1]}));
    end
  endtask : t_wor
  // Print the counts and the verdict, then stop.
  task close_out;
    $display("errors %0d, checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : close_out
  // Reset with live inputs, check idle levels, then run every scenario.
  initial begin
    {q, d, o, w} = '1;
    q.enable_n = 0;
    o[0] = 0;
    w[1:0] = 0;
    repeat (8) @(posedge clk);
    #2;
    chk({qz, dz}, 6'h0);
    chk({dzn, dez, oz, ozn}, 6'h31);
    chk(6'({wz, wzn}), 6'h1);
    repeat (8) @(posedge clk);
    #1 rst = 0;
    t_quad();
    t_dual();
    t_oct();
    t_wor();
    close_out();
  end
endmodule : test_multiplexer_family
`default_nettype wire
